// *** hdl/soft_power_wake_status.sv ***
// soft power status: button, override, alarm and wake flags
//
// How it works
// - button press sets flag; enabled raises wake
// - hold over four seconds forces override, off
// - alarm from clock sets alarm flag
// - enabled alarm wakes; powers supply if off
// - remembered alarm wakes when standby returns
// - alarm flag hardware set, write-one clear
// - override flag suppresses alarm wakeup
// - override flag hardware set, write-one clear
// - override allows only button as wake
// - wake flag never set without tracking
// - sleep-entry off plus tracking: wake sets
// - other off causes leave wake flag clear
// - wake flag cleared by write-one, resets
// - bits 1, 4, 5, 6 reserved, read zero
`timescale 1ns/1ps
`include "soft_power_defines.svh"

module soft_power_wake_status
	import soft_power_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = `HOLD_CYCLES  // long press length
) (
	input  wire logic       REF_CLK,          // 50 mhz standby clock
	input  wire logic       ARST_N,           // async reset, active low
	input  wire logic       CLK_EN,           // freezes all state when low
	input  wire logic       BAT_POR,          // battery power-on reset pulse
	input  wire logic       STBY_POR,         // standby power-on reset pulse
	input  wire logic       STBY_PRESENT,     // standby power present, pin
	input  wire logic       BUTTON_IN_N,      // power button, active low pin
	input  wire logic       ALARM_IN,         // alarm pulse from clock
	input  wire logic [3:0] REG_ADDR,         // register address
	input  wire logic [7:0] REG_WDATA,        // write data
	input  wire logic       REG_WR,           // write strobe
	input  wire logic       REG_RD,           // read strobe
	output logic      [7:0] REG_RDATA,        // read data, cycle after read
	output logic            SUPPLY_ON_OUT_N,  // supply on, active low
	output logic            SUPPLY_ON_OE_N,   // low while driving the pin
	output logic            WAKE_EVENT_OUT_N, // wake event, active low
	output logic            IRQ               // level interrupt
);

	localparam int CW = $clog2(HOLD_CYCLES + 1);  // counter width

	reg_req_t       req;              // bundled bus request
	logic [2:0]     btn_sync_q;       // button synchroniser chain
	logic [2:0]     alm_sync_q;       // alarm synchroniser chain
	logic [2:0]     stby_sync_q;      // standby synchroniser chain
	logic           btn_q;            // filtered button level
	logic           alm_q;            // filtered alarm level
	logic           stby_q;           // filtered standby level
	logic           alm_prev_q;       // alarm level last cycle
	logic           btn_prev_q;       // button level last cycle
	logic           stby_prev_q;      // standby level last cycle
	logic [CW-1:0]  hold_cnt_q;       // long press counter
	logic           press_q;          // button press flag
	logic           alarm_q;          // alarm flag
	logic           override_q;       // button override flag
	logic           wake_q;           // wake flag
	logic           btn_en_q;         // button event enable
	logic           alm_en_q;         // alarm wake enable
	logic           track_en_q;       // wake tracking enable
	logic           sleep_en_q;       // sleep entry enable
	logic           mem_en_q;         // alarm memory enable
	logic           slept_q;          // off was caused by sleep entry
	supply_state_t  state_q;          // supply state
	logic [3:0]     irq_sts_q;        // sticky interrupt status
	logic [3:0]     irq_mask_q;       // interrupt mask
	logic           btn_rise;         // button newly pressed
	logic           alm_rise;         // alarm newly fired
	logic           stby_rise;        // standby power returned
	logic           long_press;       // hold limit reached
	logic           alarm_wake;       // alarm wake request
	logic           wake_any;         // any accepted wakeup
	logic           wr_sts;           // status write
	logic [7:0]     status_byte;      // assembled status byte
	logic [3:0]     irq_evt;          // events into interrupt status

	assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

	// pin synchronisers; stage 0 feeds stage 1 only
	// standby resets present: a low start would fake a power loss
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			btn_sync_q  <= 3'h0;
			alm_sync_q  <= 3'h0;
			stby_sync_q <= 3'h7;
		end else if (CLK_EN) begin
			btn_sync_q  <= {btn_sync_q[1:0], ~BUTTON_IN_N};
			alm_sync_q  <= {alm_sync_q[1:0], ALARM_IN};
			stby_sync_q <= {stby_sync_q[1:0], STBY_PRESENT};
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			btn_q  <= 1'b0;
			alm_q  <= 1'b0;
			stby_q <= 1'b1;
		end else if (CLK_EN) begin
			if (btn_sync_q[1] == btn_sync_q[2]) begin
				btn_q <= btn_sync_q[2];
			end
			if (alm_sync_q[1] == alm_sync_q[2]) begin
				alm_q <= alm_sync_q[2];
			end
			if (stby_sync_q[1] == stby_sync_q[2]) begin
				stby_q <= stby_sync_q[2];
			end
		end
	end

	// previous levels for edge detection
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			btn_prev_q  <= 1'b0;
			alm_prev_q  <= 1'b0;
			stby_prev_q <= 1'b1;
		end else if (CLK_EN) begin
			btn_prev_q  <= btn_q;
			alm_prev_q  <= alm_q;
			stby_prev_q <= stby_q;
		end
	end

	assign btn_rise  = btn_q & ~btn_prev_q;
	assign alm_rise  = alm_q & ~alm_prev_q;
	assign stby_rise = stby_q & ~stby_prev_q;
	assign wr_sts    = req.wr && req.addr == `OFS_STATUS;

	// hold counter restart
	// counts only while held; saturates so one long press fires once
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			hold_cnt_q <= '0;
		end else if (CLK_EN) begin
			if (!btn_q) begin
				hold_cnt_q <= '0;
			end else if (hold_cnt_q != CW'(HOLD_CYCLES)) begin
				hold_cnt_q <= hold_cnt_q + 1'b1;
			end
		end
	end

	assign long_press = btn_q && hold_cnt_q == CW'(HOLD_CYCLES - 1);

	// button press flag
	// long press clear wins; otherwise the set beats software clear
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			press_q <= 1'b0;
		end else if (CLK_EN) begin
			if (BAT_POR || long_press) begin
				press_q <= 1'b0;
			end else if (btn_rise) begin
				press_q <= 1'b1;
			end else if (wr_sts && req.wdata[`BIT_BUTTON_PRESS]) begin
				press_q <= 1'b0;
			end
		end
	end

	// override flag, hardware set, write-one clear
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			override_q <= 1'b0;
		end else if (CLK_EN) begin
			if (BAT_POR) begin
				override_q <= 1'b0;
			end else if (long_press) begin
				override_q <= 1'b1;
			end else if (wr_sts && req.wdata[`BIT_OVERRIDE]) begin
				override_q <= 1'b0;
			end
		end
	end

	// alarm flag set by alarm edge
	// cleared only by write-one or battery reset
	// alarm without standby is latched only with alarm memory enabled
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			alarm_q <= 1'b0;
		end else if (CLK_EN) begin
			if (BAT_POR) begin
				alarm_q <= 1'b0;
			end else if (alm_rise && (stby_q || mem_en_q)) begin
				alarm_q <= 1'b1;
			end else if (wr_sts && req.wdata[`BIT_ALARM]) begin
				alarm_q <= 1'b0;
			end
		end
	end

	// only the button wakes while override is set
	assign alarm_wake = ((alm_rise && alm_en_q)
		|| (stby_rise && mem_en_q && alarm_q)) && !override_q;
	assign wake_any = btn_rise || alarm_wake;

	// software enables and supply control
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			btn_en_q   <= 1'b0;
			alm_en_q   <= 1'b0;
			track_en_q <= 1'b0;
			sleep_en_q <= 1'b0;
			mem_en_q   <= 1'b0;
			irq_mask_q <= `RST_IRQ;
		end else if (CLK_EN) begin
			if (BAT_POR) begin
				btn_en_q   <= 1'b0;
				alm_en_q   <= 1'b0;
				track_en_q <= 1'b0;
				mem_en_q   <= 1'b0;
			end else if (req.wr && req.addr == `OFS_ENABLE) begin
				btn_en_q <= req.wdata[`BIT_BUTTON_EN];
				alm_en_q <= req.wdata[`BIT_ALARM_EN];
			end else if (req.wr && req.addr == `OFS_SUPPLY_CTRL) begin
				track_en_q <= req.wdata[`BIT_WAKE_TRACK];
				mem_en_q   <= req.wdata[`BIT_ALARM_MEMORY];
			end else if (req.wr && req.addr == `OFS_IRQ_MASK) begin
				irq_mask_q <= req.wdata[3:0];
			end
			// sleep entry is a self-clearing command
			sleep_en_q <= req.wr && req.addr == `OFS_SUPPLY_CTRL
				&& req.wdata[`BIT_SLEEP_ENTRY] && !BAT_POR;
		end
	end

	// supply state machine
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= SUPPLY_ON;
			slept_q <= 1'b0;
		end else if (CLK_EN) begin
			unique case (state_q)
				SUPPLY_ON: begin
					if (!stby_q) begin
						state_q <= SUPPLY_LOW;
						slept_q <= 1'b0;
					end else if (long_press) begin
						state_q <= SUPPLY_OFF;
						slept_q <= 1'b0;
					end else if (sleep_en_q) begin
						state_q <= SUPPLY_OFF;
						slept_q <= 1'b1;
					end
				end
				SUPPLY_OFF: begin
					if (!stby_q) begin
						state_q <= SUPPLY_LOW;
						slept_q <= 1'b0;
					end else if (wake_any) begin
						state_q <= SUPPLY_ON;
					end
				end
				SUPPLY_LOW: begin
					// power loss: return leaves wake flag alone
					if (stby_q) begin
						state_q <= (stby_rise && alarm_wake) ? SUPPLY_ON
							: SUPPLY_OFF;
					end
				end
				default: state_q <= SUPPLY_ON;
			endcase
		end
	end

	// set by wakeup after sleep entry
	// other off causes never set it
	// write-one clear and both power resets
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wake_q <= 1'b0;
		end else if (CLK_EN) begin
			if (BAT_POR || STBY_POR) begin
				wake_q <= 1'b0;
			end else if (state_q == SUPPLY_OFF && slept_q && track_en_q
				&& wake_any) begin
				wake_q <= 1'b1;
			end else if (wr_sts && req.wdata[`BIT_WAKE]) begin
				wake_q <= 1'b0;
			end
		end
	end

	assign status_byte = {wake_q, 3'h0, override_q, alarm_q, 1'b0, press_q};

	// interrupt status, set beats write-one clear
	assign irq_evt = {wake_any && slept_q && track_en_q
		&& state_q == SUPPLY_OFF, long_press, alm_rise, btn_rise};
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_sts_q <= `RST_IRQ;
		end else if (CLK_EN) begin
			if (req.wr && req.addr == `OFS_IRQ_STATUS) begin
				irq_sts_q <= (irq_sts_q & ~req.wdata[3:0]) | irq_evt;
			end else begin
				irq_sts_q <= irq_sts_q | irq_evt;
			end
		end
	end

	// read data, cycle after the strobe only
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			REG_RDATA <= `RST_BYTE;
		end else if (CLK_EN) begin
			if (!req.rd) begin
				REG_RDATA <= `RST_BYTE;
			end else begin
				unique case (req.addr)
					`OFS_STATUS: REG_RDATA <= status_byte;
					`OFS_ENABLE: REG_RDATA <= {5'h0, alm_en_q, 1'b0, btn_en_q};
					`OFS_SUPPLY_CTRL: REG_RDATA <= {5'h0, mem_en_q, 1'b0,
						track_en_q};
					`OFS_IRQ_STATUS: REG_RDATA <= {4'h0, irq_sts_q};
					`OFS_IRQ_MASK: REG_RDATA <= {4'h0, irq_mask_q};
					default: REG_RDATA <= `RST_BYTE;
				endcase
			end
		end
	end

	// registered outputs; supply driven low when on, floats otherwise
	// wake event while press flag and enable set
	// alarm flag with enable raises wake event while override is clear
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			SUPPLY_ON_OUT_N  <= 1'b0;
			SUPPLY_ON_OE_N   <= 1'b0;
			WAKE_EVENT_OUT_N <= 1'b1;
			IRQ              <= 1'b0;
		end else if (CLK_EN) begin
			SUPPLY_ON_OUT_N  <= 1'b0;
			SUPPLY_ON_OE_N   <= state_q != SUPPLY_ON;
			WAKE_EVENT_OUT_N <= !((press_q && btn_en_q)
				|| (alarm_q && alm_en_q && !override_q));
			IRQ              <= |(irq_sts_q & irq_mask_q);
		end
	end

	// override must float the supply two edges later
	a_override_floats: assert property (@(posedge REF_CLK)
		disable iff (!ARST_N) (CLK_EN && long_press && stby_q
		&& state_q == SUPPLY_ON) ##1 CLK_EN |=> SUPPLY_ON_OE_N)
		else $error("supply not floated after long press");

	a_press_cleared: assert property (@(posedge REF_CLK)
		disable iff (!ARST_N) CLK_EN && long_press |=> !press_q && override_q)
		else $error("long press did not swap flags");

	a_alarm_hw_only: assert property (@(posedge REF_CLK)
		disable iff (!ARST_N) $rose(alarm_q) |-> $past(alm_rise))
		else $error("alarm flag set without alarm");

	// only a button edge may bring the supply back under override
	a_override_blocks: assert property (@(posedge REF_CLK)
		disable iff (!ARST_N) CLK_EN && override_q && !btn_rise
		&& state_q != SUPPLY_ON |=> state_q != SUPPLY_ON)
		else $error("supply woke by other source during override");

	a_override_hw_only: assert property (@(posedge REF_CLK)
		disable iff (!ARST_N) $rose(override_q) |-> $past(long_press))
		else $error("override set without long press");

	a_wake_needs_track: assert property (@(posedge REF_CLK)
		disable iff (!ARST_N) $rose(wake_q) |-> $past(track_en_q)
		&& $past(slept_q))
		else $error("wake flag set without tracking");

	a_wake_por_clear: assert property (@(posedge REF_CLK)
		disable iff (!ARST_N) CLK_EN && (STBY_POR || BAT_POR) |=> !wake_q)
		else $error("wake flag survived power reset");

	// reserved status bits must read back as zero on the port
	a_reserved_zero: assert property (@(posedge REF_CLK)
		disable iff (!ARST_N) CLK_EN && REG_RD
		&& REG_ADDR == `OFS_STATUS |=> REG_RDATA[6:4] == 3'h0
		&& !REG_RDATA[1])
		else $error("reserved status bit set");

	sequence s_held_release;
		btn_q && CLK_EN ##1 !btn_q && CLK_EN;
	endsequence
	a_hold_restart: assert property (@(posedge REF_CLK)
		disable iff (!ARST_N) s_held_release |=> hold_cnt_q == '0)
		else $error("hold counter not restarted");

endmodule : soft_power_wake_status

// *** hdl/soft_power_defines.svh ***
// offsets, bit positions, reset values and timing counts of the soft power block
`ifndef SOFT_POWER_DEFINES_SVH
`define SOFT_POWER_DEFINES_SVH

// register offsets on the plain register port
`define OFS_STATUS        4'h0
`define OFS_ENABLE        4'h1
`define OFS_SUPPLY_CTRL   4'h2
`define OFS_IRQ_STATUS    4'h3
`define OFS_IRQ_MASK      4'h4

// status byte bit positions
`define BIT_BUTTON_PRESS  0
`define BIT_ALARM         2
`define BIT_OVERRIDE      3
`define BIT_WAKE          7

// enable register bit positions
`define BIT_BUTTON_EN     0
`define BIT_ALARM_EN      2

// supply control bit positions
`define BIT_WAKE_TRACK    0
`define BIT_SLEEP_ENTRY   1
`define BIT_ALARM_MEMORY  2

// interrupt status bit positions
`define BIT_IRQ_PRESS     0
`define BIT_IRQ_ALARM     1
`define BIT_IRQ_OVERRIDE  2
`define BIT_IRQ_WAKE      3

// reset values
`define RST_BYTE          8'h00
`define RST_IRQ           4'h0

// long press hold time
`define HOLD_TIME_MS      4000
`define CLK_FREQ_HZ       50000000
`define HOLD_CYCLES       (`HOLD_TIME_MS * (`CLK_FREQ_HZ / 1000))

`endif

// *** hdl/soft_power_pkg.sv ***
// types shared by the soft power status block
package soft_power_pkg;

	// supply state machine, one-hot
	typedef enum logic [2:0] {
		SUPPLY_ON  = 3'b001,
		SUPPLY_OFF = 3'b010,
		SUPPLY_LOW = 3'b100
	} supply_state_t;

	// software register access carrier
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

endpackage : soft_power_pkg

// *** verif/button_supply_model.sv ***
// behavioural power button and supply rail on the far side of the block
`timescale 1ns/1ps

module button_supply_model (
	input  wire logic press,     // bench asks for the button to be held
	input  wire logic pin_out_n, // drive value on the supply pin
	input  wire logic pin_oe_n,  // low while the block drives the pin
	output logic      button_n,  // button contact, low when pressed
	output logic      supply_up  // rail on while the pin sits low
);
	logic pin_level; // resolved wire level of the supply pin

	// floating means off
	// board pull-up, so a released pin never passes for a driven low
	assign pin_level = pin_oe_n ? 1'b1 : pin_out_n;
	// rail follows the active-low request
	assign supply_up = ~pin_level;
	// contact closes to ground while held
	assign button_n = ~press;
endmodule : button_supply_model

// *** verif/soft_power_wake_status_tb.sv ***
// register-level bench for the soft power status block
`timescale 1ns/1ps
`include "soft_power_defines.svh"

module soft_power_wake_status_tb;
	localparam int unsigned HOLD = 20; // short long-press for simulation
	logic       ref_clk = 1'b0;      // 50 mhz clock
	logic       arst_n = 1'b0;       // reset held at start
	logic       clk_en = 1'b1;       // run enable
	logic       bat_por = 1'b0;      // battery reset pulse
	logic       stby_por = 1'b0;     // standby reset pulse
	logic       stby_present = 1'b1; // standby power pin
	logic       alarm_in = 1'b0;     // alarm from the clock
	logic       press = 1'b0;        // button held request
	logic [3:0] reg_addr = 4'h0;     // register address
	logic [7:0] reg_wdata = 8'h00;   // write data
	logic       reg_wr = 1'b0;       // write strobe
	logic       reg_rd = 1'b0;       // read strobe
	logic [7:0] reg_rdata;           // read data
	logic       out_n;               // supply pin drive value
	logic       oe_n;                // supply pin enable
	logic       wake_n;              // wake event, active low
	logic       irq;                 // level interrupt
	logic       button_n;            // button pin from the model
	logic       supply_up;           // rail state from the model
	int         err_total = 0;       // mismatches
	int         checked = 0;         // comparisons

	// free-running clock
	always #10 ref_clk = ~ref_clk;

	soft_power_wake_status #(.HOLD_CYCLES(HOLD)) soft_power_wake_status_i (
		.REF_CLK(ref_clk), .ARST_N(arst_n), .CLK_EN(clk_en),
		.BAT_POR(bat_por), .STBY_POR(stby_por),
		.STBY_PRESENT(stby_present), .BUTTON_IN_N(button_n),
		.ALARM_IN(alarm_in), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.SUPPLY_ON_OUT_N(out_n), .SUPPLY_ON_OE_N(oe_n),
		.WAKE_EVENT_OUT_N(wake_n), .IRQ(irq)
	);

	button_supply_model button_supply_model_i (
		.press(press), .pin_out_n(out_n), .pin_oe_n(oe_n),
		.button_n(button_n), .supply_up(supply_up)
	);

	// verdict and end of run
	task automatic end_of_test;
		if (err_total == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	// one comparison, four-state exact
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : idle

	// single-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read strobe, data looked at in the following cycle only
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask : rd

	// rail, wake line and interrupt, one edge on so registered pins settle
	task automatic pins(input logic up, input logic wk_n, input logic ir);
		@(posedge ref_clk);
		#1 check({5'h00, supply_up, wake_n, irq}, {5'h00, up, wk_n, ir});
	endtask : pins

	// hold then release, leaving time for the pin filters
	task automatic hold_button(input int n);
		@(posedge ref_clk);
		press <= 1'b1;
		idle(n);
		press <= 1'b0;
		idle(10);
	endtask : hold_button

	task automatic alarm;
		@(posedge ref_clk);
		alarm_in <= 1'b1;
		idle(4);
		alarm_in <= 1'b0;
		idle(10);
	endtask : alarm

	// main sequence
	initial begin
		idle(4);
		arst_n <= 1'b1;
		pins(1'b1, 1'b1, 1'b0);
		rd(`OFS_STATUS, 8'h00);
		rd(`OFS_ENABLE, 8'h00);
		rd(`OFS_SUPPLY_CTRL, 8'h00);
		rd(`OFS_IRQ_MASK, 8'h00);
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00);
		// writes are dropped while the clock enable is low
		@(posedge ref_clk);
		clk_en <= 1'b0;
		wr(`OFS_ENABLE, 8'h05);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		rd(`OFS_ENABLE, 8'h00);
		// short press: flag, wake line, unmasked interrupt
		wr(`OFS_ENABLE, 8'h05);
		wr(`OFS_IRQ_MASK, 8'h0f);
		hold_button(5);
		pins(1'b1, 1'b0, 1'b1);
		rd(`OFS_STATUS, 8'h01);
		rd(`OFS_IRQ_STATUS, 8'h01);
		wr(`OFS_STATUS, 8'h00);
		rd(`OFS_STATUS, 8'h01);
		wr(`OFS_STATUS, 8'h01);
		wr(`OFS_IRQ_STATUS, 8'h01);
		pins(1'b1, 1'b1, 1'b0);
		// two holds under the limit must not add up
		hold_button(15);
		hold_button(15);
		rd(`OFS_STATUS, 8'h01);
		wr(`OFS_IRQ_MASK, 8'h00);
		wr(`OFS_STATUS, 8'h01);
		wr(`OFS_IRQ_STATUS, 8'h0f);
		// long press: override and soft off
		wr(`OFS_SUPPLY_CTRL, 8'h01);
		hold_button(40);
		rd(`OFS_STATUS, 8'h08);
		pins(1'b0, 1'b1, 1'b0);
		alarm();
		rd(`OFS_STATUS, 8'h0c);
		pins(1'b0, 1'b1, 1'b0);
		wr(`OFS_STATUS, 8'h00);
		rd(`OFS_STATUS, 8'h0c);
		hold_button(5);
		pins(1'b1, 1'b0, 1'b0);
		rd(`OFS_STATUS, 8'h0d);
		// masked events stay pending and show once unmasked
		wr(`OFS_IRQ_MASK, 8'h0f);
		pins(1'b1, 1'b0, 1'b1);
		wr(`OFS_IRQ_STATUS, 8'h0f);
		pins(1'b1, 1'b0, 1'b0);
		wr(`OFS_IRQ_MASK, 8'h00);
		wr(`OFS_STATUS, 8'h0d);
		rd(`OFS_STATUS, 8'h00);
		// sleep entry with tracking, alarm wakes
		wr(`OFS_SUPPLY_CTRL, 8'h03);
		idle(4);
		rd(`OFS_SUPPLY_CTRL, 8'h01);
		pins(1'b0, 1'b1, 1'b0);
		alarm();
		pins(1'b1, 1'b0, 1'b0);
		rd(`OFS_STATUS, 8'h84);
		@(posedge ref_clk);
		stby_por <= 1'b1;
		@(posedge ref_clk);
		stby_por <= 1'b0;
		rd(`OFS_STATUS, 8'h04);
		wr(`OFS_STATUS, 8'h04);
		rd(`OFS_STATUS, 8'h00);
		// sleep entry without tracking, button wakes
		wr(`OFS_SUPPLY_CTRL, 8'h02);
		idle(4);
		hold_button(5);
		pins(1'b1, 1'b0, 1'b0);
		rd(`OFS_STATUS, 8'h01);
		wr(`OFS_STATUS, 8'h01);
		// power loss with alarm memory and tracking both on
		wr(`OFS_SUPPLY_CTRL, 8'h05);
		@(posedge ref_clk);
		stby_present <= 1'b0;
		idle(8);
		pins(1'b0, 1'b1, 1'b0);
		alarm();
		@(posedge ref_clk);
		stby_present <= 1'b1;
		idle(10);
		pins(1'b1, 1'b0, 1'b0);
		rd(`OFS_STATUS, 8'h04);
		// battery reset clears flags and enables
		@(posedge ref_clk);
		bat_por <= 1'b1;
		@(posedge ref_clk);
		bat_por <= 1'b0;
		idle(2);
		rd(`OFS_STATUS, 8'h00);
		rd(`OFS_ENABLE, 8'h00);
		pins(1'b1, 1'b1, 1'b0);
		// alarm with its wake enable clear: flag only, no wake line
		alarm();
		rd(`OFS_STATUS, 8'h04);
		pins(1'b1, 1'b1, 1'b0);
		end_of_test();
	end

	// the sequence needs about 360 cycles; twenty thousand is a hang
	initial begin
		#(20 * 20000);
		err_total++;
		end_of_test();
	end
endmodule : soft_power_wake_status_tb
